// file: verilog/switch_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// - Six channels, pin or register bit
// - Gating zero: register OR pin
// - Gating one: register AND pin
// - Floating pin reads as low
// - Config frame: write bit, bank, address
// - Reset request bit runs reset command
// - Read gives standby, control, zero top
// - Reset clears registers, not power stage
// - First transfer after reset flags error
// - Limp home: writes ignored, pins only
// - Mux all ones means standby
//
module switch_ctrl (
	input  wire logic        clk_in,         // 100 MHz
	input  wire logic        rst_b_in,       // Power-on, sync low
	input  wire logic        ce_in,          // Clock enable
	input  wire logic [7:0]  frame_in,       // Received frame
	input  wire logic        frame_valid_in, // Frame done pulse
	input  wire logic [5:0]  out_bits_in,    // Output register bits
	input  wire logic        gating_in,      // Input gating select
	input  wire logic [2:0]  mux_sel_in,     // Sense mux select
	input  wire logic [5:0]  pin_in,         // Channel input pins
	input  wire logic        limp_in,        // Limp-home pin
	output logic      [7:0]  read_data_out,  // Read answer frame
	output logic             error_flag_out, // Transfer error flag
	output logic             reg_reset_out,  // Register reset: command pulse, held high in limp home
	output logic      [5:0]  power_out       // Channel power outputs
);
	// ----------------------------------------------------------------
	// Synchronisers for pins
	// ----------------------------------------------------------------
	logic [6:0] sync1_reg; // First stage only
	logic [6:0] sync2_reg; // Second stage
	// Absent level is taken as zero at reset
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			sync1_reg <= 7'h00;
			sync2_reg <= 7'h00;
		end else if (ce_in) begin
			sync1_reg <= {limp_in, pin_in};
			sync2_reg <= sync1_reg;
		end
	end
	wire logic limp = sync2_reg[6]; // Limp level

	// ----------------------------------------------------------------
	// Configuration register
	// ----------------------------------------------------------------
	logic control_reg, control_next;   // Control bit
	logic standby_reg, standby_next;   // Standby status
	logic err_reg, err_next;           // Transfer error
	logic rstcmd_reg, rstcmd_next;     // Reset command pulse
	logic [7:0] rd_reg, rd_next;       // Read frame
	logic       is_cfg;                // Frame targets config
	logic       is_write;              // Write frame

	// Next values of the configuration group; a reset source
	// beats a frame write so no stale write survives a reset
	always_comb begin
		is_cfg = frame_in[switch_ctrl_pkg::BANK_BIT_POS]
			== switch_ctrl_pkg::BANK_CONFIG
			&& frame_in[switch_ctrl_pkg::ADDR_HI_POS:
			switch_ctrl_pkg::ADDR_LO_POS]
			== switch_ctrl_pkg::ADDR_CONFIG;
		is_write = frame_in[switch_ctrl_pkg::WRITE_BIT_POS];
		control_next = control_reg;
		standby_next = (mux_sel_in == switch_ctrl_pkg::MUX_STANDBY);
		err_next = err_reg;
		rstcmd_next = 1'b0; // Pulse, reads cleared
		rd_next = rd_reg;
		if (rstcmd_reg || limp) begin
			// Reset command or limp home clears the control bit and sets the error flag
			control_next = switch_ctrl_pkg::CONTROL_RST;
			err_next = 1'b1;
		end else if (frame_valid_in) begin
			err_next = 1'b0; // First frame consumed flag
			if (is_cfg && is_write) begin
				control_next = frame_in[switch_ctrl_pkg::CONTROL_POS];
				rstcmd_next = frame_in[switch_ctrl_pkg::RESET_REQ_POS];
			end
		end else if (frame_valid_in == 1'b0 && limp) begin
			control_next = control_reg;
		end
		// Limp home still answers reads
		if (frame_valid_in && is_cfg && !is_write) begin
			rd_next = 8'h00;
			rd_next[7:4] = frame_in[7:4];
			rd_next[switch_ctrl_pkg::ZERO_POS] = 1'b0;
			rd_next[switch_ctrl_pkg::UNDEF_POS] = 1'b0;
			rd_next[switch_ctrl_pkg::STANDBY_POS] = standby_reg;
			rd_next[switch_ctrl_pkg::CONTROL_POS] = control_reg;
		end
	end

	// Registers only; every reset value is a constant
	// Read frame stands until the next configuration read
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			control_reg <= switch_ctrl_pkg::CONTROL_RST;
			standby_reg <= 1'b0;
			err_reg     <= 1'b1;
			rstcmd_reg  <= 1'b0;
			rd_reg      <= 8'h00;
		end else if (ce_in) begin
			control_reg <= control_next;
			standby_reg <= standby_next;
			err_reg     <= err_next;
			rstcmd_reg  <= rstcmd_next && !limp;
			rd_reg      <= rd_next;
		end
	end

	// ----------------------------------------------------------------
	// Configuration checks
	// ----------------------------------------------------------------
	// Standby status tracks the mux select one edge late
	standby_follow_a : assert property (@(posedge clk_in)
		disable iff (!rst_b_in) ce_in |=> standby_reg ==
		($past(mux_sel_in) == switch_ctrl_pkg::MUX_STANDBY))
		else $error("standby status wrong");
	// Reset command lasts one cycle and clears the register
	reset_pulse_a : assert property (@(posedge clk_in)
		disable iff (!rst_b_in) rstcmd_reg && ce_in |=> !rstcmd_reg
		&& err_reg && !control_reg)
		else $error("reset command repeated");
	// Reset request bit starts the command pulse
	cmd_start_a : assert property (@(posedge clk_in)
		disable iff (!rst_b_in) ce_in && frame_valid_in && is_cfg
		&& is_write && frame_in[switch_ctrl_pkg::RESET_REQ_POS]
		&& !limp && !rstcmd_reg |=> rstcmd_reg)
		else $error("reset command not started");
	// Accepted write lands in the control bit
	write_ctl_a : assert property (@(posedge clk_in)
		disable iff (!rst_b_in) ce_in && frame_valid_in && is_write
		&& is_cfg && !limp && !rstcmd_reg |=>
		control_reg == $past(frame_in[switch_ctrl_pkg::CONTROL_POS]))
		else $error("control write lost");
	// Any frame outside a reset source consumes the error flag
	err_clear_a : assert property (@(posedge clk_in)
		disable iff (!rst_b_in) ce_in && frame_valid_in && !limp
		&& !rstcmd_reg |=> !error_flag_out)
		else $error("error flag stuck");
	// Power-on reset leaves the flag set and control cleared
	por_state_a : assert property (@(posedge clk_in)
		!rst_b_in |=> error_flag_out && !control_reg)
		else $error("reset state wrong");
	// Limp home drops writes and holds the flag
	limp_write_a : assert property (@(posedge clk_in)
		disable iff (!rst_b_in) ce_in && limp |=> !control_reg
		&& error_flag_out)
		else $error("write taken in limp home");
	// Limp home holds the other registers in reset
	limp_reset_a : assert property (@(posedge clk_in)
		disable iff (!rst_b_in) limp |-> reg_reset_out)
		else $error("limp reset missing");
	// Read answer carries standby and control of that edge
	read_echo_a : assert property (@(posedge clk_in)
		disable iff (!rst_b_in) ce_in && frame_valid_in && is_cfg
		&& !is_write |=> read_data_out[1:0] ==
		{$past(standby_reg), $past(control_reg)})
		else $error("read answer wrong");
	// Bits 3:2 of the read answer stay zero
	read_top_a : assert property (@(posedge clk_in)
		disable iff (!rst_b_in) read_data_out[3:2] == 2'h0)
		else $error("read top bits not zero");

	// ----------------------------------------------------------------
	// Matrix
	// ----------------------------------------------------------------
	switch_bus_if #(.N(switch_ctrl_pkg::CHANNELS)) bus ();
	assign bus.gating   = gating_in;
	assign bus.out_bits = out_bits_in;
	assign bus.pins     = sync2_reg[5:0];
	assign bus.limp     = limp;

	switch_matrix u_matrix (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.ce_in    (ce_in),
		.bus      (bus.matrix)
	);

	// Outputs come straight from flip-flops, except reg_reset_out, an OR of rstcmd_reg and limp
	assign power_out      = bus.drive;
	assign read_data_out  = rd_reg;
	assign error_flag_out = err_reg;
	assign reg_reset_out  = rstcmd_reg | limp;

	// ----------------------------------------------------------------
	// Matrix checks
	// ----------------------------------------------------------------
	// Register bit alone turns a channel on in OR mode
	or_mode_a : assert property (@(posedge clk_in)
		disable iff (!rst_b_in) ce_in && !limp && !gating_in
		&& out_bits_in[0] |=> power_out[0])
		else $error("or mode failed");
	// Low pin and clear bit keep a channel off
	off_idle_a : assert property (@(posedge clk_in)
		disable iff (!rst_b_in) ce_in && !limp && !out_bits_in[1]
		&& !sync2_reg[1] |=> !power_out[1])
		else $error("idle channel driven");
	// Low pin blocks the channel in gated mode
	and_mode_a : assert property (@(posedge clk_in)
		disable iff (!rst_b_in) ce_in && !limp && gating_in
		&& !sync2_reg[0] |=> !power_out[0])
		else $error("and mode failed");
	// Bit and pin together turn a gated channel on
	gate_on_a : assert property (@(posedge clk_in)
		disable iff (!rst_b_in) ce_in && !limp && gating_in
		&& out_bits_in[0] && sync2_reg[0] |=> power_out[0])
		else $error("gated channel stuck off");
	// Limp home passes the pins straight through
	limp_pins_a : assert property (@(posedge clk_in)
		disable iff (!rst_b_in) ce_in && limp |=>
		power_out == $past(sync2_reg[5:0]))
		else $error("limp output wrong");
endmodule : switch_ctrl
`default_nettype wire

// file: verilog/switch_ctrl_pkg.sv
`default_nettype none
package switch_ctrl_pkg;
	// ----------------------------------------------------------------
	// Frame layout of the configuration register
	// ----------------------------------------------------------------
	localparam int          FRAME_W       = 8;
	localparam int          WRITE_BIT_POS = 7;
	localparam int          BANK_BIT_POS  = 6;
	localparam int          ADDR_HI_POS   = 5;
	localparam int          ADDR_LO_POS   = 4;
	localparam logic        BANK_CONFIG   = 1'h1;
	localparam logic [1:0]  ADDR_CONFIG   = 2'h2;
	localparam int          RESET_REQ_POS = 1;
	localparam int          STANDBY_POS   = 1;
	localparam int          CONTROL_POS   = 0;
	localparam int          UNDEF_POS     = 2;
	localparam int          ZERO_POS      = 3;
	// ----------------------------------------------------------------
	// Reset values and other constants
	// ----------------------------------------------------------------
	localparam logic        CONTROL_RST   = 1'h0;
	localparam logic        GATING_RST    = 1'h0;
	localparam int          CHANNELS      = 6;
	localparam int          MUX_W         = 3;
	localparam logic [2:0]  MUX_STANDBY   = 3'h7;
	localparam logic [5:0]  OUT_RST       = 6'h00;
endpackage : switch_ctrl_pkg
`default_nettype wire

// file: verilog/switch_bus_if.sv
`timescale 1ns/100ps
`default_nettype none
// Channel request and pin levels between controller and matrix
interface switch_bus_if #(parameter int N = 6);
	logic         gating;   // Input gating select
	logic [N-1:0] out_bits; // Output register bits
	logic [N-1:0] pins;     // Synchronised pin levels
	logic         limp;     // Limp-home active
	logic [N-1:0] drive;    // Resulting channel drive
	modport ctrl (output gating, out_bits, pins, limp, input drive);
	modport matrix (input gating, out_bits, pins, limp, output drive);
endinterface : switch_bus_if
`default_nettype wire

// file: verilog/switch_matrix.sv
`timescale 1ns/100ps
`default_nettype none
// Per-channel input switch matrix, registered drive
module switch_matrix (
	input  wire logic   clk_in,
	input  wire logic   rst_b_in,
	input  wire logic   ce_in,
	switch_bus_if.matrix bus
);
	logic [switch_ctrl_pkg::CHANNELS-1:0] drive_reg;  // Registered drive
	logic [switch_ctrl_pkg::CHANNELS-1:0] drive_next; // Next drive

	// ----------------------------------------------------------------
	// Matrix per channel
	// ----------------------------------------------------------------
	for (genvar i = 0; i < switch_ctrl_pkg::CHANNELS; i++) begin : g_ch
		always_comb begin
			// Limp home: pins only
			if (bus.limp) begin
				drive_next[i] = bus.pins[i];
			end else if (bus.gating) begin
				drive_next[i] = bus.out_bits[i] & bus.pins[i];
			end else begin
				drive_next[i] = bus.out_bits[i] | bus.pins[i];
			end
		end
	end

	// Power stage is not reset by any reset source
	always_ff @(posedge clk_in) begin
		if (ce_in) begin
			drive_reg <= drive_next;
		end
	end
	assign bus.drive = drive_reg;
endmodule : switch_matrix
`default_nettype wire

// file: dv/pin_source.sv
`timescale 1ns/100ps
`default_nettype none
// Far side: host pins; undriven pin sinks to low
module pin_source (
	input  wire logic [5:0] level_in, // Host pin level
	input  wire logic [5:0] drive_in, // Host drives pin
	output logic      [5:0] pin_out   // Level at device pin
);
	// Released pin pulled low by the sink
	assign pin_out = level_in & drive_in;
endmodule // pin_source
`default_nettype wire

// file: dv/tb_high_side_switch_control.sv
`timescale 1ns/100ps
`default_nettype none
module tb_high_side_switch_control;
	logic       clk_in         = 1'b0;
	logic       rst_b_in       = 1'b0;
	logic       frame_valid_in = 1'b0;
	logic       gating_in      = 1'b0;
	logic       limp_in        = 1'b0;
	logic [7:0] frame_in       = 8'h00;
	logic [5:0] out_bits_in    = 6'h00;
	logic [5:0] lvl            = 6'h00;
	logic [5:0] drv            = 6'h00;
	logic [2:0] mux_sel_in     = 3'h0;
	logic       ce_in          = 1'b1;
	logic       reg_reset_out;
	int         rr_count       = 0;
	logic [5:0] pin_in;
	logic [7:0] read_data_out;
	logic       error_flag_out;
	logic [5:0] power_out;
	int         err_count      = 0;
	int         tests_run      = 0;
	// Clock, 10 ns period
	always #5 clk_in = ~clk_in;
	// Counts cycles with the register reset output high
	always @(negedge clk_in)
		if (reg_reset_out === 1'b1)
			rr_count <= rr_count + 1;
	pin_source u_pins (.level_in(lvl), .drive_in(drv), .pin_out(pin_in));
	switch_ctrl u_dut (
		.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
		.frame_in(frame_in), .frame_valid_in(frame_valid_in),
		.out_bits_in(out_bits_in), .gating_in(gating_in),
		.mux_sel_in(mux_sel_in), .pin_in(pin_in), .limp_in(limp_in),
		.read_data_out(read_data_out), .error_flag_out(error_flag_out),
		.reg_reset_out(reg_reset_out), .power_out(power_out));
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// One frame; returns once answer and reset walk have landed
	task automatic send(input logic [7:0] f);
		@(negedge clk_in);
		frame_in = f;
		frame_valid_in = 1'b1;
		@(negedge clk_in);
		frame_valid_in = 1'b0;
		cyc(2);
	endtask
	task automatic chk(input string nm, input logic [7:0] e, g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Config read; answer echoes read bit, bank and address
	task automatic rd(input logic [3:0] e);
		send(8'h60);
		chk("config", {4'h6, e}, read_data_out);
	endtask
	// Pin path is 3 edges deep; 4 leaves margin
	task automatic pw(input logic [5:0] e);
		cyc(4);
		chk("power", {2'h0, e}, {2'h0, power_out});
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		cyc(6);
		rst_b_in = 1'b1;
		chk("error flag", 8'h01, {7'h0, error_flag_out});
		send(8'hE1);
		rd(4'h1);
		chk("error flag", 8'h00, {7'h0, error_flag_out});
		mux_sel_in = 3'h7;
		cyc(4);
		rd(4'h3);
		mux_sel_in = 3'h0;
		cyc(4);
		rd(4'h1);
		// Matrix: OR, then gated, then released pins
		out_bits_in = 6'h02;
		drv = 6'h3F;
		lvl = 6'h01;
		pw(6'h03);
		// Clock enable low freezes the drive despite a pin change
		ce_in = 1'b0;
		lvl = 6'h00;
		pw(6'h03);
		ce_in = 1'b1;
		gating_in = 1'b1;
		out_bits_in = 6'h03;
		lvl = 6'h05;
		pw(6'h01);
		gating_in = 1'b0;
		out_bits_in = 6'h00;
		drv = 6'h00;
		lvl = 6'h3F;
		pw(6'h00);
		// Reset command keeps the power stage, clears control
		out_bits_in = 6'h01;
		pw(6'h01);
		send(8'hE3);
		chk("error flag", 8'h01, {7'h0, error_flag_out});
		chk("reset pulses", 8'h01, rr_count[7:0]);
		pw(6'h01);
		rd(4'h0);
		rd(4'h0);
		chk("error flag", 8'h00, {7'h0, error_flag_out});
		chk("reset pulses", 8'h01, rr_count[7:0]);
		// Mid-run power-on reset spares the power stage too
		send(8'hE1);
		rst_b_in = 1'b0;
		cyc(6);
		rst_b_in = 1'b1;
		chk("error flag", 8'h01, {7'h0, error_flag_out});
		pw(6'h01);
		rd(4'h0);
		// Limp home: registers cleared, write refused, pins drive
		send(8'hE1);
		limp_in = 1'b1;
		out_bits_in = 6'h3F;
		drv = 6'h3F;
		lvl = 6'h04;
		cyc(4);
		chk("reset out", 8'h01, {7'h0, reg_reset_out});
		send(8'hE1);
		rd(4'h0);
		pw(6'h04);
		limp_in = 1'b0;
		test_done();
	end
endmodule // tb_high_side_switch_control
`default_nettype wire
